// file: sim/sem_host_model.sv
/* Host computer model: issues one status command per clock edge.
   Assumes the caller steps it just after a rising edge. */
`timescale 1ns/1ns
`default_nettype none
module sem_host_model
    import sem_pkg::*;
(
    input  wire logic     i_clock,
    output var sem_cmd_t  o_cmd,
    output var logic      o_mask_rd
);
    initial o_cmd = '0;
    initial o_mask_rd = 1'b0;
    // Command held over exactly one rising edge; mask words are weight sums
    task automatic issue(input logic [2:0] op, input logic [1:0] s, input logic [15:0] d,
                         input logic mk);
        o_cmd = '{rd: op[2], wr: op[1], preset: op[0], sel: s, wdata: d};
        o_mask_rd = mk;
        @(posedge i_clock);
    endtask
endmodule
`default_nettype wire

// file: sim/sem_status_sva.sv
/* Checker for the status event block, bound to its ports.
   Assumes one clock and the synchronous active high reset. */
`timescale 1ns/1ns
`default_nettype none
module sem_status_sva
    import sem_pkg::*;
(
    input wire logic        i_clock,
    input wire logic        i_rst,
    input wire sem_cond_t   i_cond,
    input wire sem_cmd_t    i_cmd,
    input wire logic        i_mask_rd,
    input wire logic [15:0] o_rdata,
    input wire logic        o_rvalid,
    input wire logic        o_sum_meas,
    input wire logic        o_sum_ques,
    input wire logic        o_sum_oper,
    input wire logic        o_fault
);
    default clocking dc @(posedge i_clock); endclocking
    default disable iff (i_rst);
    logic [15:0] used_bits;
    // Implemented bits of the word being read
    always_ff @(posedge i_clock)
        used_bits <= i_mask_rd ? 16'hFFFF : (i_cmd.sel == 2'h0) ? 16'h03BF :
                     (i_cmd.sel == 2'h1) ? 16'h0310 : (i_cmd.sel == 2'h2) ? 16'h0531 : 16'h0000;
    // Host command shapes
    sequence meas_quiet_rd;
        i_cmd.rd && i_cmd.sel == 2'h0 && !i_mask_rd && i_cond[18:10] == 9'h000;
    endsequence
    sequence meas_all_wr;
        i_cmd.wr && !i_cmd.preset && i_cmd.sel == 2'h0 && i_cmd.wdata == 16'hFFFF;
    endsequence
    sequence ovr_rise;
        i_cond.reading_overrange && !$past(i_cond.reading_overrange) && !i_cmd.wr && !i_cmd.preset;
    endsequence
    sequence hold_bad;
        (i_cond.cal_const_invalid && !i_cond.cal_done_ok ##1 !i_cond.cal_done_ok) or
        (i_cond.self_trim_invalid_flag && !i_cond.self_trim_ok ##1 !i_cond.self_trim_ok);
    endsequence
    sequence mask_back;
        i_cmd.wr && !i_cmd.preset && i_cmd.sel != 2'h3 ##1
        i_cmd.rd && i_mask_rd && !i_cmd.preset && i_cmd.sel == $past(i_cmd.sel);
    endsequence
    unused_zero_a:
        assert property (o_rvalid |-> (o_rdata & ~used_bits) == 16'h0000) else $error("unused bit set");
    read_clear_a:
        assert property (meas_quiet_rd ##1 meas_quiet_rd |=> o_rdata == 16'h0000)
        else $error("flags survived a read");
    preset_gate_a:
        assert property (i_cmd.preset |=> !(o_sum_meas || o_sum_ques || o_sum_oper))
        else $error("summary after preset");
    sum_set_a:
        assert property (meas_all_wr ##1 ovr_rise |=> o_sum_meas) else $error("summary missing");
    fault_on_a:
        assert property (i_cond.ref_junction_invalid |=> o_fault) else $error("fault missing");
    fault_off_a:
        assert property (!o_fault && i_cond[9:8] == 2'b00 && !i_cond.self_trim_invalid_flag &&
            !$past(i_cond.cal_const_invalid) && !$past(i_cond.self_trim_invalid_flag) |=> !o_fault)
        else $error("fault without cause");
    hold_fault_a:
        assert property (hold_bad |=> o_fault) else $error("hold latch lost");
    mask_back_a:
        assert property (mask_back |=> o_rdata == $past(i_cmd.wdata, 2)) else $error("mask readback");
endmodule
bind sem_status sem_status_sva u_sva (.i_clock, .i_rst, .i_cond, .i_cmd, .i_mask_rd, .o_rdata,
    .o_rvalid, .o_sum_meas, .o_sum_ques, .o_sum_oper, .o_fault);
`default_nettype wire

// file: sim/tb.sv
/* Self-checking bench for the status event block with a reference model.
   Assumes the host model and checker are compiled alongside. */
`timescale 1ns/1ns
`default_nettype none
module tb;
    import sem_pkg::*;
    logic        i_clock, i_rst, i_mask_rd, o_rvalid, o_sum_meas, o_sum_ques, o_sum_oper, o_fault;
    logic        ch, th, ex_rv, ex_f;
    logic [2:0]  ex_sum;
    logic [15:0] o_rdata, ex_rd;
    logic [15:0] mf [3];
    logic [15:0] mm [3];
    sem_cond_t   i_cond, pc, r;
    sem_cmd_t    i_cmd;
    int          n_errors, total_checks, seed, x;
    sem_status u_dut (.i_clock, .i_rst, .i_cond, .i_cmd, .i_mask_rd, .o_rdata, .o_rvalid,
        .o_sum_meas, .o_sum_ques, .o_sum_oper, .o_fault);
    sem_host_model u_host (.i_clock, .o_cmd(i_cmd), .o_mask_rd(i_mask_rd));
    // Clock
    initial
    begin
        i_clock = 1'b0;
        forever #20 i_clock = ~i_clock;
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    function automatic sem_cond_t one(input int p);
        return sem_cond_t'(19'h00001 << p);
    endfunction
    task automatic cy(input sem_cond_t c, input logic [2:0] op, input logic [1:0] s,
                      input logic [15:0] d, input logic mk);
        #1;
        i_cond = c;
        u_host.issue(op, s, d, mk);
    endtask
    task automatic summarize();
        $display("checks=%0d errors=%0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // Reference model: compare outputs, then advance one edge
    always @(posedge i_clock)
    begin
        if (i_rst)
        begin
            mf = '{default: 16'h0000};
            mm = '{default: 16'h0000};
            {ch, th, ex_rv, ex_f, ex_sum, pc} = '0;
        end
        else
        begin
            chk({15'h0000, o_rvalid}, {15'h0000, ex_rv});
            if (ex_rv)
                chk(o_rdata, ex_rd);
            chk({13'h0000, o_sum_oper, o_sum_ques, o_sum_meas}, {13'h0000, ex_sum});
            chk({15'h0000, o_fault}, {15'h0000, ex_f});
            r = i_cond & ~pc;
            ex_rv = i_cmd.rd;
            if (i_cmd.rd)
                ex_rd = (i_cmd.sel == 2'h3) ? 16'h0000 : i_mask_rd ? mm[i_cmd.sel] :
                        mf[i_cmd.sel] | ((i_cmd.sel == 2'h1) ? {6'h00, th, ch, 8'h00} : 16'h0000);
            if (i_cmd.rd && !i_mask_rd && i_cmd.sel != 2'h3)
                mf[i_cmd.sel] = 16'h0000;
            mf[0] |= {6'h00, r[10], r[11], r[12], 1'b0, r[13], r[14], r[15], r[16], r[17], r[18]};
            mf[1] |= {11'h000, r[9], 4'h0};
            mf[2] |= {5'h00, r[0], 1'b0, r[1], 2'h0, r[2], r[3], 3'h0, r[4]};
            // Failure wins over success in the same cycle
            ch = (ch & ~i_cond[7]) | i_cond[8];
            th = (th & ~i_cond[5]) | i_cond[6];
            ex_f = i_cond[9] | ch | th;
            if (i_cmd.preset)
                mm = '{default: 16'h0000};
            else if (i_cmd.wr && i_cmd.sel != 2'h3)
                mm[i_cmd.sel] = i_cmd.wdata;
            ex_sum = {|(mf[2] & mm[2]), |((mf[1] | {6'h00, th, ch, 8'h00}) & mm[1]), |(mf[0] & mm[0])};
            pc = i_cond;
        end
    end
    // Watchdog
    initial
    begin
        #(40 * 5000);
        n_errors++;
        summarize();
    end
    // Main sequence
    initial
    begin
        {seed, n_errors, total_checks} = {32'd96265, 64'd0};
        i_cond = '0;
        i_rst = 1'b1;
        repeat (3) @(posedge i_clock);
        #1 i_rst = 1'b0;
        @(posedge i_clock);
        for (int s = 0; s < 8; s++)
            cy('0, s[2] ? 3'b100 : 3'b010, s[1:0], 16'hA5C3 >> s, s[2]);
        cy('0, 3'b001, 2'h0, 16'h0000, 1'b0);
        for (int s = 0; s < 3; s++)
            cy('0, 3'b100, s[1:0], 16'h0000, 1'b1);
        $display("test masks done");
        cy('0, 3'b010, 2'h0, 16'hFFFF, 1'b0);
        cy(one(18), 3'b000, 2'h0, 16'h0000, 1'b0);
        cy('0, 3'b100, 2'h0, 16'h0000, 1'b0);
        cy('0, 3'b010, 2'h0, 16'h0000, 1'b0);
        cy(one(17), 3'b000, 2'h0, 16'h0000, 1'b0);
        repeat (2) cy('0, 3'b100, 2'h0, 16'h0000, 1'b0);
        $display("test summary done");
        cy('0, 3'b010, 2'h1, 16'hFFFF, 1'b0);
        for (int k = 0; k < 2; k++)
        begin
            cy(one(k ? 6 : 8), 3'b000, 2'h1, 16'h0000, 1'b0);
            repeat (2) cy('0, 3'b100, 2'h1, 16'h0000, 1'b0);
            cy(one(k ? 5 : 7), 3'b000, 2'h1, 16'h0000, 1'b0);
            cy('0, 3'b100, 2'h1, 16'h0000, 1'b0);
        end
        $display("test holds done");
        cy('0, 3'b010, 2'h2, 16'hFFFF, 1'b0);
        for (int p = 0; p < 19; p++)
        begin
            cy(one(p), 3'b000, 2'h0, 16'h0000, 1'b0);
            cy('0, 3'b100, (p > 9) ? 2'h0 : (p == 9) ? 2'h1 : 2'h2, 16'h0000, 1'b0);
        end
        $display("test conditions done");
        repeat (3000)
        begin
            x = $random(seed);
            cy(sem_cond_t'(x[18:0] & 19'h7FE1F), {x[20:19] == 2'h0, x[22:21] == 2'h0,
               x[28:23] == 6'h00}, x[30:29], 16'($random(seed)), x[31]);
        end
        $display("test random done");
        cy('0, 3'b000, 2'h0, 16'h0000, 1'b0);
        summarize();
    end
endmodule
`default_nettype wire

// file: src/sem_map.svh
/*
 Bit positions, register selectors and reset values for the status event block.
 Assumes inclusion by bare name from the design module.
*/
`ifndef SEM_MAP_SVH
`define SEM_MAP_SVH

// Register selectors on the command port
`define SEM_SEL_MEAS          2'h0
`define SEM_SEL_QUES          2'h1
`define SEM_SEL_OPER          2'h2

// Measurement event bit positions
`define SEM_MEAS_OVR          0
`define SEM_MEAS_LO1          1
`define SEM_MEAS_HI1          2
`define SEM_MEAS_LO2          3
`define SEM_MEAS_HI2          4
`define SEM_MEAS_RDY          5
`define SEM_MEAS_AVL          7
`define SEM_MEAS_HALF         8
`define SEM_MEAS_FULL         9

// Questionable event bit positions
`define SEM_QUES_TEMP         4
`define SEM_QUES_CAL          8
`define SEM_QUES_TRIM         9

// Operation event bit positions
`define SEM_OPER_CAL          0
`define SEM_OPER_MEAS         4
`define SEM_OPER_TRIG         5
`define SEM_OPER_FILT         8
`define SEM_OPER_IDLE         10

// Implemented bits per register
`define SEM_MEAS_USED         16'h03BF
`define SEM_QUES_USED         16'h0310
`define SEM_OPER_USED         16'h0531

// Reset values
`define SEM_FLAGS_RST         16'h0000
`define SEM_MASK_RST          16'h0000

`endif

// file: src/sem_pkg.sv
/*
 Types for the status event block.
 Assumes sem_map.svh is on the include path.
*/
package sem_pkg;

    // Raw condition inputs from the instrument
    typedef struct packed {
        logic reading_overrange;
        logic below_first_lower_bound;
        logic above_first_upper_bound;
        logic below_second_lower_bound;
        logic above_second_upper_bound;
        logic sample_ready;
        logic store_has_samples;
        logic store_half_occupied;
        logic store_occupied;
        logic ref_junction_invalid;
        logic cal_const_invalid;
        logic cal_done_ok;
        logic self_trim_invalid_flag;
        logic self_trim_ok;
        logic calibrating;
        logic measuring;
        logic trigger_wait;
        logic filter_settled;
        logic idle;
    } sem_cond_t;

    // Host command
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic        preset;
        logic [1:0]  sel;
        logic [15:0] wdata;
    } sem_cmd_t;

    // Whole block state
    typedef struct packed {
        logic [15:0] meas_flags;
        logic [15:0] ques_flags;
        logic [15:0] oper_flags;
        logic [15:0] meas_mask;
        logic [15:0] ques_mask;
        logic [15:0] oper_mask;
        logic        cal_hold;
        logic        trim_hold;
        sem_cond_t   prev;
        logic [15:0] rdata;
        logic        rvalid;
        logic        sum_meas;
        logic        sum_ques;
        logic        sum_oper;
        logic        fault;
    } sem_state_t;

endpackage

// file: src/sem_status.sv
/*
 Status event block: measurement, questionable and operation event flags
 with their enable masks, summary bits and a fault indicator.
 Assumes one clock, condition inputs synchronous to it, one host command
 at a time on the command port, and a synchronous active high reset.
*/
// Contract
// - Measurement bits 0-4 flag overrange and first/second limit violations.
// - Measurement bits 5,7,8,9 flag reading done, store two, half, full.
// - Questionable bit 4 flags invalid reference junction reading.
// - Questionable bit 8 flags bad cal constant, held until calibration succeeds.
// - Questionable bit 9 flags bad self-trim, held until a later one succeeds.
// - Fault indicator is on while any questionable event is present; it follows the live reference junction condition and both holds.
// - Operation bit 0 while calibrating, bit 4 while measuring.
// - Operation bit 5 while waiting in the trigger layer.
// - Operation bit 8 on filter settled, bit 10 when idle.
// - Host writes masks as binary weight sums; 0 clears, 65535 sets all.
// - A masked flag cannot set the next-level summary bit.
// - An unmasked set flag sets the next-level summary bit.
// - Three separate masks, same bit layout, each written by its own select.
// - Reading an event register clears its bits, except questionable bits 8 and 9 while held.
// - Preset clears all three masks and nothing else.
`timescale 1ns/1ns
`default_nettype none
`include "sem_map.svh"

module sem_status
    import sem_pkg::*;
(
    input  wire logic        i_clock,
    input  wire logic        i_rst,
    input  wire sem_cond_t   i_cond,
    input  wire sem_cmd_t    i_cmd,
    input  wire logic        i_mask_rd,
    output logic [15:0]      o_rdata,
    output logic             o_rvalid,
    output logic             o_sum_meas,
    output logic             o_sum_ques,
    output logic             o_sum_oper,
    output logic             o_fault
);

    sem_state_t  st;
    sem_state_t  next_st;
    logic [15:0] meas_rise;
    logic [15:0] ques_rise;
    logic [15:0] oper_rise;
    logic [15:0] meas_level;
    logic [15:0] oper_level;

    // Map conditions into per-register bit vectors
    always_comb
    begin
        meas_level = 16'h0000;
        oper_level = 16'h0000;
        meas_level[`SEM_MEAS_OVR]  = i_cond.reading_overrange;
        meas_level[`SEM_MEAS_LO1]  = i_cond.below_first_lower_bound;
        meas_level[`SEM_MEAS_HI1]  = i_cond.above_first_upper_bound;
        meas_level[`SEM_MEAS_LO2]  = i_cond.below_second_lower_bound;
        meas_level[`SEM_MEAS_HI2]  = i_cond.above_second_upper_bound;
        meas_level[`SEM_MEAS_RDY]  = i_cond.sample_ready;
        meas_level[`SEM_MEAS_AVL]  = i_cond.store_has_samples;
        meas_level[`SEM_MEAS_HALF] = i_cond.store_half_occupied;
        meas_level[`SEM_MEAS_FULL] = i_cond.store_occupied;
        oper_level[`SEM_OPER_CAL]  = i_cond.calibrating;
        oper_level[`SEM_OPER_MEAS] = i_cond.measuring;
        oper_level[`SEM_OPER_TRIG] = i_cond.trigger_wait;
        oper_level[`SEM_OPER_FILT] = i_cond.filter_settled;
        oper_level[`SEM_OPER_IDLE] = i_cond.idle;
    end

    // Rising-edge detection of the previous condition snapshot
    always_comb
    begin
        logic [15:0] pm;
        logic [15:0] po;
        pm = 16'h0000;
        po = 16'h0000;
        pm[`SEM_MEAS_OVR]  = st.prev.reading_overrange;
        pm[`SEM_MEAS_LO1]  = st.prev.below_first_lower_bound;
        pm[`SEM_MEAS_HI1]  = st.prev.above_first_upper_bound;
        pm[`SEM_MEAS_LO2]  = st.prev.below_second_lower_bound;
        pm[`SEM_MEAS_HI2]  = st.prev.above_second_upper_bound;
        pm[`SEM_MEAS_RDY]  = st.prev.sample_ready;
        pm[`SEM_MEAS_AVL]  = st.prev.store_has_samples;
        pm[`SEM_MEAS_HALF] = st.prev.store_half_occupied;
        pm[`SEM_MEAS_FULL] = st.prev.store_occupied;
        po[`SEM_OPER_CAL]  = st.prev.calibrating;
        po[`SEM_OPER_MEAS] = st.prev.measuring;
        po[`SEM_OPER_TRIG] = st.prev.trigger_wait;
        po[`SEM_OPER_FILT] = st.prev.filter_settled;
        po[`SEM_OPER_IDLE] = st.prev.idle;
        meas_rise = meas_level & ~pm & `SEM_MEAS_USED;
        oper_rise = oper_level & ~po & `SEM_OPER_USED;
        ques_rise = 16'h0000;
        ques_rise[`SEM_QUES_TEMP] = i_cond.ref_junction_invalid
                                    & ~st.prev.ref_junction_invalid;
    end

    // Next-state logic for flags, masks, holds and outputs
    always_comb
    begin
        logic rd_m;
        logic rd_q;
        logic rd_o;
        rd_m = i_cmd.rd && !i_mask_rd && (i_cmd.sel == `SEM_SEL_MEAS);
        rd_q = i_cmd.rd && !i_mask_rd && (i_cmd.sel == `SEM_SEL_QUES);
        rd_o = i_cmd.rd && !i_mask_rd && (i_cmd.sel == `SEM_SEL_OPER);
        next_st = st;
        next_st.prev = i_cond;

        // Calibration and self-trim holds: set on failure, clear on success
        if (i_cond.cal_const_invalid)
            next_st.cal_hold = 1'b1;
        else if (i_cond.cal_done_ok)
            next_st.cal_hold = 1'b0;
        if (i_cond.self_trim_invalid_flag)
            next_st.trim_hold = 1'b1;
        else if (i_cond.self_trim_ok)
            next_st.trim_hold = 1'b0;

        // Read clears, new events win over the clear
        next_st.meas_flags = (rd_m ? `SEM_FLAGS_RST : st.meas_flags) | meas_rise;
        next_st.oper_flags = (rd_o ? `SEM_FLAGS_RST : st.oper_flags) | oper_rise;
        next_st.ques_flags = (rd_q ? `SEM_FLAGS_RST : st.ques_flags) | ques_rise;
        // Held questionable faults stay visible until their success event
        next_st.ques_flags[`SEM_QUES_CAL]  = next_st.cal_hold;
        next_st.ques_flags[`SEM_QUES_TRIM] = next_st.trim_hold;

        // Mask writes, one select per register
        if (i_cmd.wr)
        begin
            case (i_cmd.sel)
                `SEM_SEL_MEAS: next_st.meas_mask = i_cmd.wdata;
                `SEM_SEL_QUES: next_st.ques_mask = i_cmd.wdata;
                `SEM_SEL_OPER: next_st.oper_mask = i_cmd.wdata;
                default:       next_st.meas_mask = st.meas_mask;
            endcase
        end
        if (i_cmd.preset)
        begin
            next_st.meas_mask = `SEM_MASK_RST;
            next_st.ques_mask = `SEM_MASK_RST;
            next_st.oper_mask = `SEM_MASK_RST;
        end

        // Read data: event flags, or masks when i_mask_rd
        next_st.rvalid = i_cmd.rd;
        next_st.rdata  = st.rdata;
        if (i_cmd.rd)
        begin
            case (i_cmd.sel)
                `SEM_SEL_MEAS: next_st.rdata = i_mask_rd ? st.meas_mask
                                             : st.meas_flags & `SEM_MEAS_USED;
                `SEM_SEL_QUES: next_st.rdata = i_mask_rd ? st.ques_mask
                                             : st.ques_flags & `SEM_QUES_USED;
                `SEM_SEL_OPER: next_st.rdata = i_mask_rd ? st.oper_mask
                                             : st.oper_flags & `SEM_OPER_USED;
                default:       next_st.rdata = 16'h0000;
            endcase
        end

        // Summary bits from the next-state flags and masks
        next_st.sum_meas = |(next_st.meas_flags & next_st.meas_mask
                             & `SEM_MEAS_USED);
        next_st.sum_ques = |(next_st.ques_flags & next_st.ques_mask
                             & `SEM_QUES_USED);
        next_st.sum_oper = |(next_st.oper_flags & next_st.oper_mask
                             & `SEM_OPER_USED);
        // Fault follows the live reference junction condition and both holds
        next_st.fault = i_cond.ref_junction_invalid | next_st.cal_hold
                        | next_st.trim_hold;
    end

    // State register
    always_ff @(posedge i_clock)
    begin
        if (i_rst)
            st <= '0;
        else
            st <= next_st;
    end

    // Outputs straight from flops
    assign o_rdata    = st.rdata;
    assign o_rvalid   = st.rvalid;
    assign o_sum_meas = st.sum_meas;
    assign o_sum_ques = st.sum_ques;
    assign o_sum_oper = st.sum_oper;
    assign o_fault    = st.fault;

endmodule

`default_nettype wire
